// *** rtl/byte_fifo.sv ***
// Parameterised FIFO with registered read data
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  byte_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic dval_q, dval_d;
  logic full, empty, push, pop, load;
  // Occupancy flags
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign push = in_valid && !full;
  assign load = !empty && (!dval_q || out.ready);
  assign pop = load;
  assign out.valid = dval_q;
  assign out.data = dout_q;
  // Next pointer and output stage
  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    dout_d = load ? mem_q[rd_q[AW-1:0]] : dout_q;
    dval_d = load ? 1'b1 : (out.ready ? 1'b0 : dval_q);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      dval_d = 1'b0;
    end
  end
  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  // Pointer and output stage registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      dval_q <= 1'b0;
      dout_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      dval_q <= dval_d;
      dout_q <= dout_d;
    end
  end
endmodule

// *** rtl/byte_stream_if.sv ***
// Byte stream carrier between the sequencer and its FIFO
`timescale 1ns/100ps
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// *** rtl/sf_read_pkg.sv ***
// Constants for the serial flash read and status command front end
package sf_read_pkg;
  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam int ADDR_BITS = 19;
  localparam logic [18:0] ADDR_LAST = 19'h7FFFF;
  localparam logic [18:0] ADDR_FIRST = 19'h00000;
  localparam int CMD_BITS = 8;
  localparam int ADDR_FRAME_BITS = 24;
  localparam int DUMMY_BITS = 8;
  // Density code field, value is arbitrary
  localparam logic [3:0] DENSITY_CODE = 4'hA;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DENS_LSB = 2;
  localparam logic [7:0] STAT_UNDEF_VALUE = 8'h00;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_STATUS, ST_IGNORE
  } seq_state_t;
endpackage

// *** rtl/sf_read_seq.sv ***
// Serial flash command front end for array read and status read
`timescale 1ns/100ps
module sf_read_seq (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic op_busy,
  output logic [18:0] mem_addr,
  output logic mem_req,
  input wire logic mem_ready,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data
);
  // Pin synchronisers
  logic [1:0] cs_sync_q, sck_sync_q, si_sync_q;
  logic cs_s, sck_s, si_s, sck_prev_q;
  logic sck_rise, sck_fall, cs_rise;
  logic cs_prev_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n};
      sck_sync_q <= {sck_sync_q[0], sck};
      si_sync_q <= {si_sync_q[0], si};
      sck_prev_q <= sck_sync_q[1];
      cs_prev_q <= cs_sync_q[1];
    end
  end
  assign cs_s = cs_sync_q[1];
  assign sck_s = sck_sync_q[1];
  assign si_s = si_sync_q[1];
  assign sck_rise = sck_s && !sck_prev_q && !cs_s;
  assign sck_fall = !sck_s && sck_prev_q && !cs_s;
  assign cs_rise = cs_s && !cs_prev_q;

  // Live status byte, bit 0 from self-timed engine only
  logic [7:0] status_live;
  always_comb begin
    status_live = sf_read_pkg::STAT_UNDEF_VALUE;
    status_live[sf_read_pkg::STAT_DENS_LSB +: 4] = sf_read_pkg::DENSITY_CODE;
    status_live[sf_read_pkg::STAT_BUSY_BIT] = op_busy;
  end

  // FIFO between array fetch and serialiser
  byte_stream_if fifo_out();
  logic fifo_flush, fifo_in_ready;
  byte_fifo #(
    .WIDTH(sf_read_pkg::FIFO_WIDTH),
    .DEPTH(sf_read_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .flush(fifo_flush),
    .in_valid(mem_valid),
    .in_ready(fifo_in_ready),
    .in_data(mem_data),
    .out(fifo_out)
  );

  // Sequencer state
  sf_read_pkg::seq_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] shin_q, shin_d;
  logic [7:0] shout_q, shout_d;
  logic [18:0] addr_q, addr_d;
  logic [5:0] inflight_q, inflight_d;
  logic so_q, so_d, oe_q, oe_d;
  logic [2:0] bit_q, bit_d;
  logic fetch_en_q, fetch_en_d;
  logic fast_q, fast_d;
  logic mem_go;

  // Fetch ahead while room remains in the FIFO for outstanding bytes
  assign mem_go = fetch_en_q && mem_ready && fifo_in_ready &&
                  (inflight_q < 6'(sf_read_pkg::FIFO_DEPTH - 2));
  assign fifo_flush = cs_s;
  assign fifo_out.ready = (state_q == sf_read_pkg::ST_READ) && sck_fall &&
                          (bit_q == 3'h7);
  assign mem_req = mem_go;
  assign mem_addr = addr_q;

  // Next state computation
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shin_d = shin_q;
    shout_d = shout_q;
    addr_d = addr_q;
    so_d = so_q;
    oe_d = oe_q;
    bit_d = bit_q;
    fetch_en_d = fetch_en_q;
    fast_d = fast_q;
    inflight_d = inflight_q;
    if (mem_go && !(fifo_out.ready && fifo_out.valid)) begin
      inflight_d = inflight_q + 6'h01;
    end else if (!mem_go && fifo_out.ready && fifo_out.valid && inflight_q != 6'h00) begin
      inflight_d = inflight_q - 6'h01;
    end
    if (mem_go) begin
      addr_d = (addr_q == sf_read_pkg::ADDR_LAST) ? sf_read_pkg::ADDR_FIRST :
               addr_q + 19'h00001;
    end
    if (cs_s) begin
      state_d = sf_read_pkg::ST_IDLE;
      cnt_d = 5'h00;
      oe_d = 1'b0;
      so_d = 1'b0;
      fetch_en_d = 1'b0;
      inflight_d = 6'h00;
      bit_d = 3'h0;
    end else begin
      unique case (state_q)
        sf_read_pkg::ST_IDLE: begin
          state_d = sf_read_pkg::ST_OPCODE;
          cnt_d = 5'h00;
        end
        sf_read_pkg::ST_OPCODE: begin
          if (sck_rise) begin
            shin_d = {shin_q[6:0], si_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(sf_read_pkg::CMD_BITS - 1)) begin
              cnt_d = 5'h00;
              if ({shin_q[6:0], si_s} == sf_read_pkg::OP_READ_FAST ||
                  {shin_q[6:0], si_s} == sf_read_pkg::OP_READ_SLOW) begin
                state_d = sf_read_pkg::ST_ADDR;
                fast_d = ({shin_q[6:0], si_s} == sf_read_pkg::OP_READ_FAST);
              end else if ({shin_q[6:0], si_s} == sf_read_pkg::OP_STATUS) begin
                state_d = sf_read_pkg::ST_STATUS;
                shout_d = status_live;
                bit_d = 3'h0;
              end else begin
                state_d = sf_read_pkg::ST_IGNORE;
              end
            end
          end
        end
        sf_read_pkg::ST_ADDR: begin
          if (sck_rise) begin
            // Only the low address bits are kept
            addr_d = {addr_q[17:0], si_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(sf_read_pkg::ADDR_FRAME_BITS - 1)) begin
              cnt_d = 5'h00;
              if (fast_q) begin
                state_d = sf_read_pkg::ST_DUMMY;
              end else begin
                state_d = sf_read_pkg::ST_READ;
              end
              fetch_en_d = 1'b1;
              bit_d = 3'h0;
            end
          end
        end
        sf_read_pkg::ST_DUMMY: begin
          if (sck_rise) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(sf_read_pkg::DUMMY_BITS - 1)) begin
              cnt_d = 5'h00;
              state_d = sf_read_pkg::ST_READ;
            end
          end
        end
        sf_read_pkg::ST_READ: begin
          if (sck_fall) begin
            oe_d = 1'b1;
            if (bit_q == 3'h0) begin
              shout_d = {fifo_out.data[6:0], 1'b0};
              so_d = fifo_out.data[7];
            end else begin
              so_d = shout_q[7];
              shout_d = {shout_q[6:0], 1'b0};
            end
            bit_d = bit_q + 3'h1;
          end
        end
        sf_read_pkg::ST_STATUS: begin
          if (sck_fall) begin
            oe_d = 1'b1;
            if (bit_q == 3'h0) begin
              so_d = status_live[7];
              shout_d = {status_live[6:0], 1'b0};
            end else begin
              so_d = shout_q[7];
              shout_d = {shout_q[6:0], 1'b0};
            end
            bit_d = bit_q + 3'h1;
          end else if (bit_q == 3'h0 && oe_q) begin
            so_d = status_live[sf_read_pkg::STAT_BUSY_BIT];
          end
        end
        sf_read_pkg::ST_IGNORE: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= sf_read_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      shin_q <= 8'h00;
      shout_q <= 8'h00;
      addr_q <= 19'h00000;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      bit_q <= 3'h0;
      fetch_en_q <= 1'b0;
      fast_q <= 1'b0;
      inflight_q <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      addr_q <= addr_d;
      so_q <= so_d;
      oe_q <= oe_d;
      bit_q <= bit_d;
      fetch_en_q <= fetch_en_d;
      fast_q <= fast_d;
      inflight_q <= inflight_d;
    end
  end
  assign so = so_q;
  assign so_oe = oe_q;

  // Output released within two cycles after select is seen high
  a_release_on_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_s |=> ##1 !so_oe) else $error("SO driven while deselected");
  // Address wraps to zero
  a_addr_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    (mem_go && addr_q == sf_read_pkg::ADDR_LAST && !cs_s) |=> addr_q == 19'h00000)
    else $error("address did not wrap");
  // Address advances by one per fetch
  a_addr_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    (mem_go && addr_q != sf_read_pkg::ADDR_LAST && state_q == sf_read_pkg::ST_READ && !cs_s)
    |=> addr_q == $past(addr_q) + 19'h00001) else $error("address did not step");
  // Unknown opcode never drives SO
  a_ignore_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == sf_read_pkg::ST_IGNORE |=> !so_oe) else $error("SO driven on ignored op");
  // Density field queued behind bit 6 in the status shifter
  a_density_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == sf_read_pkg::ST_STATUS && bit_q == 3'h2)
    |-> shout_q[7:4] == sf_read_pkg::DENSITY_CODE) else $error("density code wrong");
  // Status first bit is bit 7 of live status
  a_status_msb: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == sf_read_pkg::ST_STATUS && sck_fall && bit_q == 3'h0 && !cs_s)
    |=> so == $past(status_live[7])) else $error("status not MSB first");
  // Halted clock after bit 0 tracks busy
  a_live_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == sf_read_pkg::ST_STATUS && bit_q == 3'h0 && oe_q && !sck_fall && !cs_s)
    |=> so == $past(op_busy)) else $error("busy not live on SO");
  // Deselect clears the bit counter
  a_cnt_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_s |=> cnt_q == 5'h00 && state_q == sf_read_pkg::ST_IDLE)
    else $error("counter not cleared");
  // No output before opcode is complete
  a_opcode_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == sf_read_pkg::ST_OPCODE |-> !so_oe) else $error("SO driven during opcode");
  // Address and dummy phases never drive SO
  a_addr_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == sf_read_pkg::ST_ADDR |-> !so_oe) else $error("SO driven during address");
  a_dummy_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == sf_read_pkg::ST_DUMMY |-> !so_oe) else $error("SO driven during dummy byte");
  // A fetched byte is waiting whenever the serialiser starts one
  a_fifo_fed: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == sf_read_pkg::ST_READ && sck_fall && bit_q == 3'h0 && !cs_s)
    |-> fifo_out.valid) else $error("array byte not ready for SO");
endmodule

// *** tb/spi_host_model.sv ***
// Host side model of the serial link master, mode 0 framing
`timescale 1ns/100ps
module spi_host_model (
  input wire logic core_clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  realtime half = 62.5;

  // Idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Select fall then opcode, kept clear of core clock edges
  task automatic open_frame(input logic [7:0] op);
    logic [31:0] rx;
    logic oe;
    @(posedge core_clk);
    #1.3 cs_n = 1'b0;
    #(half);
    xfer({24'h000000, op}, 8, rx, oe);
  endtask

  // Shift n bits MSB first; SO taken just before each rise
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx,
                      output logic oe_seen);
    rx = 32'h00000000;
    oe_seen = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #(half);
      rx = {rx[30:0], so_oe ? so : ~so};
      oe_seen = oe_seen | so_oe;
      sck = 1'b1;
      #(half);
      sck = 1'b0;
    end
  endtask

  // Select rise ends the frame; SI no longer holds its last value
  task automatic close_frame();
    #(half);
    cs_n = 1'b1;
    si = ~si;
    #(half); // Minimum deselect time
  endtask

  // Clock and data activity while deselected
  task automatic wiggle(input int n, output logic oe_seen);
    oe_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = ~si;
      #(half);
      oe_seen = oe_seen | so_oe;
      sck = 1'b1;
      #(half);
      sck = 1'b0;
    end
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the serial flash read and status front end
`timescale 1ns/100ps
module testbench;
  logic core_clk;
  logic reset_n = 1'b0;
  logic op_busy = 1'b0;
  logic mem_ready = 1'b0;
  logic mem_valid = 1'b0;
  logic [7:0] mem_data = 8'h00;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic [18:0] mem_addr;
  logic mem_req;
  logic [31:0] rx;
  logic oe;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  sf_read_seq dut (.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so), .so_oe(so_oe), .op_busy(op_busy), .mem_addr(mem_addr),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_valid(mem_valid), .mem_data(mem_data));

  spi_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe(so_oe));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Array contents as a function of address
  function automatic logic [7:0] pat(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'h5A;
  endfunction

  // Expected status byte; undefined bits read 0
  function automatic logic [7:0] st(input logic b);
    return {2'b00, sf_read_pkg::DENSITY_CODE, 1'b0, b};
  endfunction

  // Array model: stalls every other cycle, answers one cycle after a fetch
  always @(posedge core_clk) begin
    mem_ready <= ~mem_ready;
    mem_valid <= mem_req & mem_ready;
    mem_data <= pat(mem_addr);
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Slow read across the top of the array with high address bits set
  task automatic t_slow_read();
    host.open_frame(sf_read_pkg::OP_READ_SLOW);
    host.xfer(32'h00F7FFFE, 24, rx, oe);
    host.xfer(32'h00000000, 24, rx, oe);
    chk("byte 7FFFE", pat(19'h7FFFE), rx[23:16]);
    chk("byte 7FFFF", pat(19'h7FFFF), rx[15:8]);
    chk("byte wrap", pat(19'h00000), rx[7:0]);
    chk("so_oe in read", 8'h01, {7'h00, oe});
    host.close_frame();
    repeat (10) @(posedge core_clk);
    chk("so_oe after rise", 8'h00, {7'h00, so_oe});
    $display("Test slow read done");
  endtask

  // Fast read with dummy byte
  task automatic t_fast_read();
    host.open_frame(sf_read_pkg::OP_READ_FAST);
    host.xfer(32'h00012345, 24, rx, oe);
    host.xfer(32'h000000FF, 8, rx, oe);
    host.xfer(32'h00000000, 16, rx, oe);
    chk("fast byte 0", pat(19'h12345), rx[15:8]);
    chk("fast byte 1", pat(19'h12346), rx[7:0]);
    host.close_frame();
    $display("Test fast read done");
  endtask

  // Status passes, halted clock polling, fresh value afterwards
  task automatic t_status();
    @(posedge core_clk);
    op_busy <= 1'b1;
    host.open_frame(sf_read_pkg::OP_STATUS);
    host.xfer(32'h00000000, 15, rx, oe);
    chk("status busy", st(1'b1), rx[14:7]);
    chk("status repeat", st(1'b1) >> 1, {1'b0, rx[6:0]});
    repeat (10) @(posedge core_clk);
    chk("halted so busy", 8'h01, {7'h00, so});
    @(posedge core_clk);
    op_busy <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("halted so ready", 8'h00, {7'h00, so});
    host.xfer(32'h00000000, 9, rx, oe);
    chk("status fresh", st(1'b0), rx[7:0]);
    host.close_frame();
    $display("Test status done");
  endtask

  // Unknown opcode leaves SO released
  task automatic t_unknown();
    host.open_frame(8'hA5);
    host.xfer(32'h0000FFFF, 16, rx, oe);
    chk("so_oe unknown op", 8'h00, {7'h00, oe});
    host.close_frame();
    $display("Test unknown opcode done");
  endtask

  // Clocking while deselected is ignored and framing restarts clean
  task automatic t_deselect();
    host.wiggle(5, oe);
    chk("so_oe deselected", 8'h00, {7'h00, oe});
    host.open_frame(sf_read_pkg::OP_STATUS);
    host.xfer(32'h00000000, 8, rx, oe);
    chk("status after idle", st(1'b0), rx[7:0]);
    host.close_frame();
    $display("Test deselect done");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_slow_read();
    t_fast_read();
    t_status();
    t_unknown();
    t_deselect();
    complete_run();
  end
endmodule
